// File: hdl/presettable_ripple_counter.sv
`include "ripple_counter_cfg.svh"
module presettable_ripple_counter #(
  parameter bit DECADE = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clock1,
  input wire logic clock2,
  input wire ripple_counter_pkg::ctrl_t ctrl,
  output logic [3:0] q
);
  // ------------------------------------------------------------
  // edge detection on sampled pin clocks
  // ------------------------------------------------------------
  logic clk1_ff;
  logic clk2_ff;
  logic a_ff;
  logic [2:0] upper_ff;
  logic fall1;
  logic fall2;
  logic [2:0] top;
  logic [2:0] nxt_upper;
  logic armed_ff;

  // the first sample after reset only primes the detectors: a pin that
  // idles low (clock2 fed from a low stage output) must not count a fall
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      armed_ff <= 1'b0;
    else
      armed_ff <= 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clk1_ff <= 1'b1;
      clk2_ff <= 1'b1;
    end
    else
    begin
      clk1_ff <= clock1;
      clk2_ff <= clock2;
    end
  end

  // falling edges only
  // edges are only valid once the detector has seen a real pin level
  assign fall1 = armed_ff & clk1_ff & ~clock1;
  assign fall2 = armed_ff & clk2_ff & ~clock2;

  // decade upper section is divide-by-five, binary divide-by-eight
  assign top = DECADE ? `RC_DECADE_MAX : `RC_BINARY_MAX;

  // ------------------------------------------------------------
  // upper section step
  // ------------------------------------------------------------
  // an out-of-range loaded value also falls back to zero on the next step,
  // which keeps the decade section from running through dead states
  function automatic logic [2:0] upper_next(input logic [2:0] cur, input logic [2:0] lim);
    upper_next = cur + `RC_UPPER_STEP;
    if (cur >= lim)
      upper_next = `RC_UPPER_ZERO;
  endfunction : upper_next

  // upper stages wrap after final state
  always_comb
  begin
    nxt_upper = upper_next(upper_ff, top);
  end

  // ------------------------------------------------------------
  // first stage, own clock
  // ------------------------------------------------------------
  // stage a on clock1 only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      a_ff <= 1'b0;
    else if (!ctrl.clear_n)
      a_ff <= 1'b0;
    else if (!ctrl.load_n)
      a_ff <= ctrl.data[0];
    else if (fall1)
      a_ff <= ~a_ff;
  end

  // ------------------------------------------------------------
  // upper three stages on clock2
  // ------------------------------------------------------------
  // second clock input, cascade via externally
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      upper_ff <= 3'h0;
    else if (!ctrl.clear_n)
      upper_ff <= 3'h0;
    else if (!ctrl.load_n)
      upper_ff <= ctrl.data[3:1];
    else if (fall2)
      upper_ff <= nxt_upper;
  end

  // outputs registered one cycle behind the stages so they come from a flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= `RC_ZERO;
    else
      q <= {upper_ff, a_ff};
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // clear reaches outputs
  a_clear_zero: assert property (@(posedge clk) disable iff (rst)
    !ctrl.clear_n |=> ##1 (q == `RC_ZERO))
    else $error("clear did not zero outputs");
  a_clear_first: assert property (@(posedge clk) disable iff (rst)
    (!ctrl.clear_n && fall1) |=> (a_ff == 1'b0))
    else $error("first stage toggled during clear");
  a_clear_stage: assert property (@(posedge clk) disable iff (rst)
    !ctrl.clear_n |=> (a_ff == 1'b0 && upper_ff == `RC_UPPER_ZERO))
    else $error("stages not held clear");
  a_clear_quiet: assert property (@(posedge clk) disable iff (rst)
    (!ctrl.clear_n && $past(!ctrl.clear_n) && $past(!ctrl.clear_n, 2)) |-> (q == `RC_ZERO))
    else $error("output transient during clear");
  a_load_value: assert property (@(posedge clk) disable iff (rst)
    (ctrl.clear_n && !ctrl.load_n) |=> ##1 (q == $past(ctrl.data, 2)))
    else $error("load value not transferred");
  a_q_follow: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (q == $past({upper_ff, a_ff})))
    else $error("outputs do not follow stages");
  // first stage ignores clock during load
  a_load_blocks: assert property (@(posedge clk) disable iff (rst)
    (ctrl.clear_n && !ctrl.load_n && fall1) |=> (a_ff == $past(ctrl.data[0])))
    else $error("clock acted during load");
  // upper stages ignore clock during load
  a_load_upper: assert property (@(posedge clk) disable iff (rst)
    (ctrl.clear_n && !ctrl.load_n) |=> (upper_ff == $past(ctrl.data[3:1])))
    else $error("upper stages missed load");
  a_hold_idle: assert property (@(posedge clk) disable iff (rst)
    (ctrl.clear_n && ctrl.load_n && !fall1) |=> $stable(a_ff))
    else $error("first stage changed without clock");
  // no count on the priming sample
  a_armed_quiet: assert property (@(posedge clk) disable iff (rst)
    (ctrl.clear_n && ctrl.load_n && !armed_ff) |=> ($stable(a_ff) && $stable(upper_ff)))
    else $error("stages moved before detector primed");
  a_armed_set: assert property (@(posedge clk) disable iff (rst)
    !armed_ff |=> armed_ff)
    else $error("edge detector never primed");
  a_first_toggle: assert property (@(posedge clk) disable iff (rst)
    (ctrl.clear_n && ctrl.load_n && fall1) |=> (a_ff != $past(a_ff)))
    else $error("first stage missed falling edge");
  a_upper_step: assert property (@(posedge clk) disable iff (rst)
    (ctrl.clear_n && ctrl.load_n && fall2 && upper_ff < top) |=>
    (upper_ff == $past(upper_ff) + 3'h1))
    else $error("upper stages did not advance");
  a_upper_wrap: assert property (@(posedge clk) disable iff (rst)
    (ctrl.clear_n && ctrl.load_n && fall2 && upper_ff == top) |=> (upper_ff == 3'h0))
    else $error("upper stages did not wrap");
  // every step lands inside the sequence
  a_upper_range: assert property (@(posedge clk) disable iff (rst)
    (ctrl.clear_n && ctrl.load_n && fall2) |=> (upper_ff <= top))
    else $error("upper stages outside sequence");
  // upper stages only on second clock
  a_upper_sep: assert property (@(posedge clk) disable iff (rst)
    (ctrl.clear_n && ctrl.load_n && !fall2) |=> $stable(upper_ff))
    else $error("upper stages moved without second clock");
  // first stage only on its own clock
  a_first_sep: assert property (@(posedge clk) disable iff (rst)
    (ctrl.clear_n && ctrl.load_n && fall2 && !fall1) |=> $stable(a_ff))
    else $error("first stage moved on second clock");

  // ------------------------------------------------------------
  // coverage of the main scenarios
  // ------------------------------------------------------------
  c_load: cover property (@(posedge clk) disable iff (rst) !ctrl.load_n ##1 ctrl.load_n);
  c_clear: cover property (@(posedge clk) disable iff (rst) !ctrl.clear_n ##1 ctrl.clear_n);
  c_wrap: cover property (@(posedge clk) disable iff (rst) fall2 && upper_ff == top);
  c_toggle: cover property (@(posedge clk) disable iff (rst) fall1 && a_ff);
  c_load_count: cover property (@(posedge clk) disable iff (rst)
    !ctrl.load_n ##1 ctrl.load_n ##[1:40] fall1);
endmodule : presettable_ripple_counter

// File: hdl/ripple_counter_cfg.svh
`ifndef RIPPLE_COUNTER_CFG_SVH
`define RIPPLE_COUNTER_CFG_SVH
`define RC_ZERO 4'h0
`define RC_DECADE_MAX 3'h4
`define RC_BINARY_MAX 3'h7
`define RC_UPPER_ZERO 3'h0
`define RC_UPPER_STEP 3'h1
`endif

// File: hdl/ripple_counter_pkg.sv
package ripple_counter_pkg;
  typedef struct packed {
    logic load_n;
    logic clear_n;
    logic [3:0] data;
  } ctrl_t;
endpackage : ripple_counter_pkg

// File: sim/cascade_link.sv
module cascade_link (
  input wire logic pulse,
  input wire logic a_out,
  output logic clock1,
  output logic clock2
);
  timeunit 1ns;
  timeprecision 1ns;
  assign clock2 = a_out;
  // idle high so a fall is seen
  assign clock1 = ~pulse;
endmodule : cascade_link

// File: sim/tb_presettable_ripple_counter.sv
module tb_presettable_ripple_counter;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pulse = 1'b0;
  logic clock1;
  logic clock2;
  ripple_counter_pkg::ctrl_t ctrl = '{1'b1, 1'b1, 4'h0};
  logic [3:0] q;
  logic [31:0] lf = 32'hAB3BEB07;
  int errors = 0;
  int n_checks = 0;
  int cnt;
  int p;
  presettable_ripple_counter #(.DECADE(1'b1)) u_presettable_ripple_counter (.clk(clk),
    .rst(rst), .clock1(clock1), .clock2(clock2), .ctrl(ctrl), .q(q));
  cascade_link u_cascade_link (.pulse(pulse), .a_out(q[0]), .clock1(clock1),
    .clock2(clock2));
  initial forever #4 clk = ~clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic chk(input string nm);
    n_checks++;
    if (q !== cnt[3:0])
    begin
      errors++;
      $display("MISMATCH %s expected %0d seen %b", nm, cnt, q);
    end
  endtask : chk
  // one fall then rise of the first-stage clock
  task automatic tick;
    pulse = 1'b1;
    wt(4);
    pulse = 1'b0;
    wt(8);
  endtask : tick
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  initial
  begin
    wt(16);
    rst = 1'b0;
    wt(2);
    cnt = 0;
    chk("reset");
    repeat (3)
    begin
      lf = lfsr_next(lf);
      p = lf[3:0] % 10;
      ctrl.data = 4'(p);
      ctrl.load_n = 1'b0;
      tick();
      ctrl.load_n = 1'b1;
      wt(20);
      cnt = p;
      chk("load_hold");
      repeat (10 - p)
      begin
        tick();
        cnt = (cnt + 1) % 10;
        chk("count");
      end
      ctrl.data = 4'h7;
      ctrl.load_n = 1'b0;
      wt(4);
      ctrl.clear_n = 1'b0;
      tick();
      cnt = 0;
      chk("clear");
      ctrl.clear_n = 1'b1;
      ctrl.load_n = 1'b1;
      wt(4);
    end
    $display("test counting done");
    test_done();
  end
  initial
  begin
    #20000;
    errors++;
    test_done();
  end
endmodule : tb_presettable_ripple_counter
